/* rtl/iowd_params.svh */
`ifndef IOWD_PARAMS_SVH
`define IOWD_PARAMS_SVH

// ----------------------------------------
// port map
// ----------------------------------------
`define IOWD_ADDR_W 16
`define IOWD_DATA_W 8
`define IOWD_CTRL_ADDR 16'h0062
`define IOWD_KICK_ADDR 16'h0066
`define IOWD_ACK_BIT 7
`define IOWD_LED_BIT 6
`define IOWD_CTRL_RESET 7'h00
`define IOWD_KICK_RDATA 8'h00
`define IOWD_UNMAP_RDATA 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define IOWD_CLK_MHZ 25
`define IOWD_TICK_US 1000
`define IOWD_TICK_CYCLES (`IOWD_TICK_US * `IOWD_CLK_MHZ)
`define IOWD_DIV_W 16
`define IOWD_CNT_W 17

// timeouts in ms, standard timebase
`define IOWD_STD_0 17'd94
`define IOWD_STD_1 17'd210
`define IOWD_STD_2 17'd340
`define IOWD_STD_3 17'd460
`define IOWD_STD_4 17'd590
`define IOWD_STD_5 17'd710
`define IOWD_STD_6 17'd840
`define IOWD_STD_7 17'd960
// timeouts in ms, extended timebase (2 s .. 64 s)
`define IOWD_EXT_0 17'd2000
`define IOWD_EXT_1 17'd4000
`define IOWD_EXT_2 17'd6000
`define IOWD_EXT_3 17'd8000
`define IOWD_EXT_4 17'd16000
`define IOWD_EXT_5 17'd32000
`define IOWD_EXT_6 17'd48000
`define IOWD_EXT_7 17'd64000

`endif

/* rtl/iowd_pkg.sv */
`include "iowd_params.svh"

package iowd_pkg;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [`IOWD_ADDR_W-1:0] addr;
        logic [`IOWD_DATA_W-1:0] wdata;
    } iowd_io_req_t;

    // control register bits 6..0, bit 7 is the timeout flag
    typedef struct packed {
        logic led_on;
        logic [2:0] time_sel;
        logic kick_port_sel;
        logic extended;
        logic timer_enable_bit;
    } iowd_ctl_t;

    typedef enum logic [1:0] {
        IOWD_OFF = 2'h0,
        IOWD_RUN = 2'h1,
        IOWD_FIRED = 2'h3
    } iowd_state_t;

endpackage

/* rtl/iowd_timebase.sv */
`timescale 1ns/1ns
`include "iowd_params.svh"

module iowd_timebase #(
    parameter int unsigned TICK_CYCLES = `IOWD_TICK_CYCLES
) (
    input wire logic clk_i,     // system clock
    input wire logic resetn_i,  // sync reset, active low
    input wire logic restart_i, // realign the tick phase
    output logic tick_o         // one-cycle pulse per tick
);
    typedef struct packed {
        logic [`IOWD_DIV_W-1:0] cnt;
        logic tick;
    } iowd_tb_st_t;

    localparam logic [`IOWD_DIV_W-1:0] LAST = `IOWD_DIV_W'(TICK_CYCLES - 1);

    iowd_tb_st_t st_q;
    iowd_tb_st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (restart_i) begin
            // restart keeps the first tick a full period away
            st_d.cnt = '0;
        end else if (st_q.cnt == LAST) begin
            st_d.cnt = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + `IOWD_DIV_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick_o = st_q.tick;
endmodule

/* rtl/iowd_top.sv */
`timescale 1ns/1ns
`include "iowd_params.svh"

module iowd_top #(
    parameter int unsigned TICK_CYCLES = `IOWD_TICK_CYCLES
) (
    input wire logic clk_i,                        // system clock, 25 MHz
    input wire logic resetn_i,                     // sync reset, active low
    input wire iowd_pkg::iowd_io_req_t io_req_i,   // i/o port access
    output logic [`IOWD_DATA_W-1:0] io_rdata_o,    // read data, held
    output logic led_o,                            // red alarm indicator
    output logic alarm_o                           // timeout flag level
);
    import iowd_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        iowd_state_t state;
        iowd_ctl_t ctl;
        logic flag;
        logic [`IOWD_CNT_W-1:0] cnt;
        logic [`IOWD_DATA_W-1:0] rdata;
        logic led;
    } iowd_st_t;

    iowd_st_t st_q;
    iowd_st_t st_d;
    logic tick;
    logic restart;
    logic ctl_wr;
    logic ctl_rd;
    logic kick_rd;
    logic ack;
    logic expire;

    function automatic logic [`IOWD_CNT_W-1:0] sel_limit(input logic ext,
                                                         input logic [2:0] sel);
        logic [`IOWD_CNT_W-1:0] v;
        v = `IOWD_STD_0;
        case ({ext, sel})
            4'h0: v = `IOWD_STD_0;
            4'h1: v = `IOWD_STD_1;
            4'h2: v = `IOWD_STD_2;
            4'h3: v = `IOWD_STD_3;
            4'h4: v = `IOWD_STD_4;
            4'h5: v = `IOWD_STD_5;
            4'h6: v = `IOWD_STD_6;
            4'h7: v = `IOWD_STD_7;
            4'h8: v = `IOWD_EXT_0;
            4'h9: v = `IOWD_EXT_1;
            4'hA: v = `IOWD_EXT_2;
            4'hB: v = `IOWD_EXT_3;
            4'hC: v = `IOWD_EXT_4;
            4'hD: v = `IOWD_EXT_5;
            4'hE: v = `IOWD_EXT_6;
            default: v = `IOWD_EXT_7;
        endcase
        return v;
    endfunction

    // ----------------------------------------
    // millisecond timebase
    // ----------------------------------------
    iowd_timebase #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timebase (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .restart_i(restart),
        .tick_o(tick)
    );

    // ----------------------------------------
    // decode
    // ----------------------------------------
    assign ctl_wr = io_req_i.wr && (io_req_i.addr == `IOWD_CTRL_ADDR);
    assign ctl_rd = io_req_i.rd && (io_req_i.addr == `IOWD_CTRL_ADDR);
    assign kick_rd = io_req_i.rd && (io_req_i.addr == `IOWD_KICK_ADDR);
    assign ack = ctl_wr && io_req_i.wdata[`IOWD_ACK_BIT];
    // only RUN counts, and RUN is left as soon as enable drops
    assign expire = (st_q.state == IOWD_RUN) && tick
                    && (st_q.cnt == `IOWD_CNT_W'(1));

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        restart = 1'b0;
        if (ctl_wr) begin
            st_d.ctl = iowd_ctl_t'(io_req_i.wdata[`IOWD_DATA_W-2:0]);
        end
        case (st_q.state)
            IOWD_OFF: begin
                if (st_d.ctl.timer_enable_bit) begin
                    st_d.state = IOWD_RUN;
                    restart = 1'b1;
                end
            end
            IOWD_RUN: begin
                if (!st_d.ctl.timer_enable_bit) begin
                    st_d.state = IOWD_OFF;
                end else if (expire) begin
                    st_d.state = IOWD_FIRED;
                end else if (kick_rd) begin
                    restart = 1'b1;
                end else if (tick) begin
                    st_d.cnt = st_q.cnt - `IOWD_CNT_W'(1);
                end
            end
            IOWD_FIRED: begin
                // countdown stays parked until the alarm is acknowledged
                if (!st_d.ctl.timer_enable_bit) begin
                    st_d.state = IOWD_OFF;
                end else if (ack) begin
                    st_d.state = IOWD_RUN;
                    restart = 1'b1;
                end
            end
            default: begin
                st_d.state = IOWD_OFF;
            end
        endcase
        if (restart) begin
            st_d.cnt = sel_limit(st_d.ctl.extended, st_d.ctl.time_sel);
        end
        // expiry wins over an acknowledge in the same cycle
        st_d.flag = expire | (st_q.flag & ~ack);
        st_d.led = st_d.ctl.led_on | st_d.flag;
        if (ctl_rd) begin
            st_d.rdata = {st_q.flag, st_q.ctl};
        end else if (kick_rd) begin
            st_d.rdata = `IOWD_KICK_RDATA;
        end else if (io_req_i.rd) begin
            st_d.rdata = `IOWD_UNMAP_RDATA;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_q.state <= IOWD_OFF;
            st_q.ctl <= iowd_ctl_t'(`IOWD_CTRL_RESET);
            st_q.flag <= 1'b0;
            st_q.cnt <= '0;
            st_q.rdata <= '0;
            st_q.led <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign io_rdata_o = st_q.rdata;
    assign led_o = st_q.led;
    assign alarm_o = st_q.flag;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    property p_off_quiet;
        !st_q.ctl.timer_enable_bit |=> !$rose(alarm_o);
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("timeout while disabled");

    property p_kick_load;
        (kick_rd && !ctl_wr && st_q.state == IOWD_RUN && st_q.ctl.timer_enable_bit && !expire)
        |=> st_q.cnt == sel_limit($past(st_q.ctl.extended), $past(st_q.ctl.time_sel));
    endproperty
    a_kick_load: assert property (p_kick_load) else $error("kick did not reload");

    property p_reset_code;
        disable iff (1'b0) !resetn_i |=> st_q.ctl.time_sel == 3'h0 && !alarm_o;
    endproperty
    a_reset_code: assert property (p_reset_code) else $error("reset code not 000");

    property p_led;
        // back-to-back writes are legal, so only the cycle after the write is judged
        (ctl_wr && io_req_i.wdata[`IOWD_LED_BIT]) |=> led_o;
    endproperty
    a_led: assert property (p_led) else $error("led not lit");

    property p_flag_read;
        ctl_rd |=> io_rdata_o[`IOWD_ACK_BIT] == $past(alarm_o);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag readback wrong");

    property p_ack;
        (ack && !expire) |=> !alarm_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack did not clear");

    property p_kick_data;
        (kick_rd) |=> io_rdata_o == `IOWD_KICK_RDATA;
    endproperty
    a_kick_data: assert property (p_kick_data) else $error("kick data wrong");

    property p_ctl_write;
        ctl_wr |=> st_q.ctl == $past(io_req_i.wdata[`IOWD_DATA_W-2:0]);
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("control not stored");

    property p_expire;
        // a disabling write in the expiry cycle sends the timer off instead
        expire |=> alarm_o && led_o
                   && (st_q.state == IOWD_FIRED || !st_q.ctl.timer_enable_bit);
    endproperty
    a_expire: assert property (p_expire) else $error("expiry not latched");

    property p_hold;
        (alarm_o && !ack) |=> alarm_o;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");

    c_expire: cover property (expire);
    c_ack: cover property (alarm_o && ack);
    c_kick: cover property (kick_rd && st_q.state == IOWD_RUN);
endmodule

/* sim/iowd_top_tb.sv */
`timescale 1ns/1ns
`include "iowd_params.svh"

module iowd_top_tb;
    import iowd_pkg::*;

    // ----------------------------------------
    // setup
    // ----------------------------------------
    // short tick keeps the longest tested timeout (2000 ms) within the run budget
    localparam int TICKS = 10;
    localparam logic [15:0] CTRL = `IOWD_CTRL_ADDR;
    localparam logic [15:0] KICK = `IOWD_KICK_ADDR;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    iowd_io_req_t io_req_i = '0;
    logic [7:0] io_rdata_o;
    logic led_o;
    logic alarm_o;
    logic [7:0] rd_val;
    int mismatches = 0;
    int comparisons = 0;
    int std_ms[8] = '{94, 210, 340, 460, 590, 710, 840, 960};

    always #20 clk_i = ~clk_i;

    iowd_top #(.TICK_CYCLES(TICKS)) uut (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .io_req_i(io_req_i),
        .io_rdata_o(io_rdata_o),
        .led_o(led_o),
        .alarm_o(alarm_o)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // cycle counts only, tolerance of one tick plus five cycles for phase alignment
    task automatic check_near(input int got, input int exp);
        comparisons++;
        if (got < exp - 5 || got > exp + TICKS + 5) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
        @(negedge clk_i);
        io_req_i = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(negedge clk_i);
        io_req_i = '0;
    endtask

    task automatic io_read(input logic [15:0] addr);
        @(negedge clk_i);
        io_req_i = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
        @(negedge clk_i);
        io_req_i = '0;
        rd_val = io_rdata_o;
    endtask

    task automatic wait_alarm(input int limit, output int n);
        n = 0;
        while (alarm_o !== 1'b1 && n < limit) begin
            @(negedge clk_i);
            n++;
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset();
        io_read(CTRL);
        check(rd_val, 8'h00);
        check({7'h00, led_o}, 8'h00);
        check({7'h00, alarm_o}, 8'h00);
        // second reset, with the timer disabled, must clear a non-zero code
        io_write(CTRL, 8'h7E);
        resetn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        io_read(CTRL);
        check(rd_val, 8'h00);
        check({7'h00, led_o}, 8'h00);
        $display("test reset done");
    endtask

    task automatic test_regs();
        io_write(CTRL, 8'h46);
        io_read(CTRL);
        check(rd_val, 8'h46);
        check({7'h00, led_o}, 8'h01);
        io_write(CTRL, 8'h04);
        // stray writes must not reach the control register
        io_write(16'h0063, 8'h41);
        io_write(KICK, 8'h41);
        io_read(CTRL);
        check(rd_val, 8'h04);
        check({7'h00, led_o}, 8'h00);
        io_read(16'h0063);
        check(rd_val, 8'h00);
        io_read(KICK);
        // enabled, then disabled well before the 94 ms expiry
        io_write(CTRL, 8'h05);
        repeat (500) @(negedge clk_i);
        io_write(CTRL, 8'h04);
        repeat (1200) @(negedge clk_i);
        check({7'h00, alarm_o}, 8'h00);
        $display("test regs done");
    endtask

    task automatic run_timeout(input logic [7:0] ctl, input int ms);
        int n;
        io_write(CTRL, ctl);
        wait_alarm(ms * TICKS + 100, n);
        check_near(n, ms * TICKS);
        io_read(CTRL);
        check(rd_val, {1'b1, ctl[6:0]});
        check({7'h00, led_o}, 8'h01);
        io_write(CTRL, {1'b1, ctl[6:0]});
        check({7'h00, alarm_o}, 8'h00);
        check({7'h00, led_o}, {7'h00, ctl[6]});
        io_write(CTRL, 8'h04);
        $display("test timeout %0d done", ms);
    endtask

    task automatic test_kick();
        int n;
        io_write(CTRL, 8'h05);
        repeat (4) begin
            repeat (700) @(negedge clk_i);
            io_read(KICK);
        end
        check({7'h00, alarm_o}, 8'h00);
        wait_alarm(94 * TICKS + 100, n);
        check_near(n, 94 * TICKS);
        io_write(CTRL, 8'h85);
        io_write(CTRL, 8'h04);
        check({7'h00, alarm_o}, 8'h00);
        $display("test kick done");
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge clk_i);
        resetn_i = 1'b1;
        test_reset();
        test_regs();
        test_kick();
        for (int c = 0; c < 8; c++) begin
            run_timeout({2'b00, c[2:0], 3'b101}, std_ms[c]);
        end
        run_timeout(8'h07, 2000);
        run_timeout(8'h4D, 210);
        complete_run();
    end

    // expected run is about 70000 cycles
    initial begin
        repeat (95000) @(posedge clk_i);
        mismatches++;
        $display("watchdog expired at %0t", $time);
        complete_run();
    end
endmodule
